// file: core/tws_pkg.sv
/*
  Constants and state types shared by the two ends of the two-wire memory link.
  Assumes a 100 MHz master clock and a 32 ns link clock at the memory end.
*/
package tws_pkg;
  // ==========================================================================
  // Array geometry.
  localparam int ADDR_W       = 7;
  localparam int BYTE_W       = 8;
  localparam int MEM_DEPTH    = 128;
  localparam int PAGE_BYTES   = 4;
  localparam int PAGE_LSB_W   = 2;
  localparam int BITS_PER_BYTE = 8;
  // ==========================================================================
  // Timing.
  localparam int CLK_NS        = 10;
  localparam int LINK_CLK_NS   = 32;
  localparam int WR_CYCLE_MS   = 10;
  localparam int WR_CYCLES     = (WR_CYCLE_MS * 1000000) / LINK_CLK_NS;
  localparam int SCL_HALF_NS   = 5000;
  localparam int QUARTER_CYCLES = ((SCL_HALF_NS / 2) + CLK_NS - 1) / CLK_NS;
  // ==========================================================================
  // State types.
  typedef enum logic [2:0] {
    DEV_IDLE, DEV_ADDR, DEV_ACKA, DEV_WDATA, DEV_ACKW, DEV_RDATA, DEV_RACK, DEV_BUSY
  } tws_dev_state_type;
  typedef enum logic [2:0] {
    MST_IDLE, MST_START, MST_BITS, MST_ACK, MST_LOAD, MST_STOP
  } tws_mst_state_type;
endpackage

// file: core/tws_link_if.sv
/*
  The two-wire link: clock driven by the master, open-drain data line.
  Assumes the testbench joins the master and memory ends through this interface.
*/
`timescale 1ns/10ps
interface tws_link_if;
  logic scl;
  logic sda_m_out;
  logic sda_m_oe;
  logic sda_d_out;
  logic sda_d_oe;
  logic sda;

  // ==========================================================================
  // Wired-AND resolution of the data line with a pull-up.
  assign sda = ~((sda_m_oe & ~sda_m_out) | (sda_d_oe & ~sda_d_out));

  modport master (output scl, output sda_m_out, output sda_m_oe, input sda);
  modport device (input scl, input sda, output sda_d_out, output sda_d_oe);
endinterface

// file: core/tws_eeprom_dev.sv
/*
  Memory end of the two-wire link: 128 x 8 array, page buffer, write timer.
  Assumes a free-running link clock much faster than the bus clock.
*/
`timescale 1ns/10ps
module tws_eeprom_dev #(
  parameter int WR_CYCLES = tws_pkg::WR_CYCLES
) (
  input  wire logic link_clk_in,
  input  wire logic reset_in,
  tws_link_if.device link,
  output logic      busy_out,
  output logic      standby_out
);
  localparam int TW = $clog2(WR_CYCLES + 1);
  localparam logic [TW-1:0] WR_LAST = TW'(WR_CYCLES - 1);
  localparam logic [3:0] BYTE_DONE = 4'(tws_pkg::BITS_PER_BYTE);

  // ==========================================================================
  // Pin synchronisers and edge detection.
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_prev;
  logic       sda_prev;
  logic       scl_s;
  logic       sda_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;

  // Bus lines pass two flops; a third stage keeps the previous level.
  always_ff @(posedge link_clk_in) begin
    if (reset_in) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], link.scl};
      sda_sync <= {sda_sync[0], link.sda};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  // Data moves while clock is high only for start and stop.
  assign scl_s     = scl_sync[1];
  assign sda_s     = sda_sync[1];
  assign scl_rise  = scl_s & ~scl_prev;
  assign scl_fall  = ~scl_s & scl_prev;
  assign start_det = scl_s & scl_prev & sda_prev & ~sda_s;
  assign stop_det  = scl_s & scl_prev & ~sda_prev & sda_s;

  // ==========================================================================
  // Array and page buffer.
  logic [tws_pkg::BYTE_W-1:0] mem [tws_pkg::MEM_DEPTH];
  logic [tws_pkg::BYTE_W-1:0] page_buf [tws_pkg::PAGE_BYTES];
  logic [tws_pkg::BYTE_W-1:0] next_page_buf [tws_pkg::PAGE_BYTES];
  logic [tws_pkg::PAGE_BYTES-1:0] page_vld;
  logic [tws_pkg::PAGE_BYTES-1:0] next_page_vld;
  logic commit;

  // ==========================================================================
  // Protocol state.
  tws_pkg::tws_dev_state_type state;
  tws_pkg::tws_dev_state_type next_state;
  logic [tws_pkg::ADDR_W-1:0] addr;
  logic [tws_pkg::ADDR_W-1:0] next_addr;
  logic [tws_pkg::BYTE_W-1:0] sh;
  logic [tws_pkg::BYTE_W-1:0] next_sh;
  logic [3:0]                 cnt;
  logic [3:0]                 next_cnt;
  logic                       rw;
  logic                       next_rw;
  logic                       acked;
  logic                       next_acked;
  logic                       sda_low;
  logic                       next_sda_low;
  logic [TW-1:0]              timer;
  logic [TW-1:0]              next_timer;
  logic                       load_rd;
  logic [tws_pkg::BYTE_W-1:0] rd_byte;

  assign rd_byte = mem[addr];

  // Next-state logic; stop beats start, and a running write cycle beats both.
  always_comb begin
    next_state    = state;
    next_addr     = addr;
    next_sh       = sh;
    next_cnt      = cnt;
    next_rw       = rw;
    next_acked    = acked;
    next_sda_low  = sda_low;
    next_timer    = timer;
    next_page_buf = page_buf;
    next_page_vld = page_vld;
    commit        = 1'b0;
    load_rd       = 1'b0;
    if (state == tws_pkg::DEV_BUSY) begin
      // Inputs are deaf and the line stays released while the array programs.
      next_sda_low = 1'b0;
      if (timer == '0) begin
        next_state = tws_pkg::DEV_IDLE;
      end else begin
        next_timer = timer - TW'(1);
      end
    end else if (stop_det) begin
      next_sda_low = 1'b0;
      if (|page_vld) begin
        commit        = 1'b1;
        next_page_vld = '0;
        next_timer    = WR_LAST;
        next_state    = tws_pkg::DEV_BUSY;
      end else begin
        next_state = tws_pkg::DEV_IDLE;
      end
    end else if (start_det) begin
      // A repeated start drops any bytes not yet closed by a stop.
      next_state    = tws_pkg::DEV_ADDR;
      next_cnt      = 4'h0;
      next_sda_low  = 1'b0;
      next_page_vld = '0;
    end else begin
      case (state)
        tws_pkg::DEV_ADDR: begin
          if (scl_rise) begin
            next_sh  = {sh[6:0], sda_s};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == BYTE_DONE) begin
            next_addr    = sh[7:1];
            next_rw      = sh[0];
            next_sda_low = 1'b1;
            next_state   = tws_pkg::DEV_ACKA;
          end
        end
        tws_pkg::DEV_ACKA: begin
          if (scl_fall) begin
            if (rw) begin
              load_rd = 1'b1;
            end else begin
              next_sda_low = 1'b0;
              next_cnt     = 4'h0;
              next_state   = tws_pkg::DEV_WDATA;
            end
          end
        end
        tws_pkg::DEV_WDATA: begin
          if (scl_rise) begin
            next_sh  = {sh[6:0], sda_s};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == BYTE_DONE) begin
            next_page_buf[addr[1:0]] = sh;
            next_page_vld[addr[1:0]] = 1'b1;
            next_addr    = {addr[6:2], addr[1:0] + 2'h1};
            next_sda_low = 1'b1;
            next_state   = tws_pkg::DEV_ACKW;
          end
        end
        tws_pkg::DEV_ACKW: begin
          if (scl_fall) begin
            next_sda_low = 1'b0;
            next_cnt     = 4'h0;
            next_state   = tws_pkg::DEV_WDATA;
          end
        end
        tws_pkg::DEV_RDATA: begin
          if (scl_fall) begin
            if (cnt == BYTE_DONE) begin
              next_sda_low = 1'b0;
              next_state   = tws_pkg::DEV_RACK;
            end else begin
              next_sda_low = ~sh[7];
              next_sh      = {sh[6:0], 1'b0};
              next_cnt     = cnt + 4'h1;
            end
          end
        end
        tws_pkg::DEV_RACK: begin
          if (scl_rise) begin
            next_acked = ~sda_s;
          end else if (scl_fall) begin
            if (acked) begin
              load_rd = 1'b1;
            end else begin
              next_state = tws_pkg::DEV_IDLE;
            end
          end
        end
        default: begin
          next_sda_low = 1'b0;
        end
      endcase
      if (load_rd) begin
        // The first bit goes out on the same fall that ends the ninth clock.
        next_sda_low = ~rd_byte[7];
        next_sh      = {rd_byte[6:0], 1'b0};
        next_cnt     = 4'h1;
        next_addr    = addr + 7'h01;
        next_state   = tws_pkg::DEV_RDATA;
      end
    end
  end

  // Registers of the protocol state; the array itself carries no reset.
  always_ff @(posedge link_clk_in) begin
    if (reset_in) begin
      state    <= tws_pkg::DEV_IDLE;
      addr     <= 7'h00;
      sh       <= 8'h00;
      cnt      <= 4'h0;
      rw       <= 1'b0;
      acked    <= 1'b0;
      sda_low  <= 1'b0;
      timer    <= '0;
      page_vld <= 4'h0;
    end else begin
      state    <= next_state;
      addr     <= next_addr;
      sh       <= next_sh;
      cnt      <= next_cnt;
      rw       <= next_rw;
      acked    <= next_acked;
      sda_low  <= next_sda_low;
      timer    <= next_timer;
      page_vld <= next_page_vld;
    end
    page_buf <= next_page_buf;
    if (commit) begin
      for (int i = 0; i < tws_pkg::PAGE_BYTES; i++) begin
        if (page_vld[i]) begin
          mem[{addr[6:2], 2'(i)}] <= page_buf[i];
        end
      end
    end
  end

  // Open drain: the output value is always low, only the enable moves.
  assign link.sda_d_out = 1'b0;
  assign link.sda_d_oe  = sda_low;
  assign busy_out       = (state == tws_pkg::DEV_BUSY);
  assign standby_out    = (state == tws_pkg::DEV_IDLE);
endmodule

// file: core/tws_bus_master.sv
/*
  Master end of the two-wire link: makes the bus clock by division and runs
  address, write, read and polling transfers.
  Assumes one command at a time and a user that feeds write bytes on request.
*/
`timescale 1ns/10ps
module tws_bus_master #(
  parameter int QUARTER = tws_pkg::QUARTER_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  tws_link_if.master      link,
  input  wire logic       cmd_valid_in,
  output logic            cmd_ready_out,
  input  wire logic       cmd_read_in,
  input  wire logic [6:0] cmd_addr_in,
  input  wire logic [7:0] cmd_len_in,
  input  wire logic       wr_valid_in,
  input  wire logic [7:0] wr_data_in,
  output logic            wr_ready_out,
  output logic            rd_valid_out,
  output logic [7:0]      rd_data_out,
  output logic            done_out,
  output logic            nack_out
);
  localparam logic [15:0] Q_LAST = 16'(QUARTER - 1);

  // ==========================================================================
  // Data line synchroniser; the memory answers from another clock domain.
  logic [1:0] sda_sync;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sda_sync <= 2'h3;
    end else begin
      sda_sync <= {sda_sync[0], link.sda};
    end
  end

  // ==========================================================================
  // Bit sequencer: four quarters per bus clock, sampled in the third.
  tws_pkg::tws_mst_state_type state;
  tws_pkg::tws_mst_state_type next_state;
  logic [15:0] qcnt;
  logic [15:0] next_qcnt;
  logic [1:0]  phase;
  logic [1:0]  next_phase;
  logic [2:0]  cnt;
  logic [2:0]  next_cnt;
  logic [7:0]  sh;
  logic [7:0]  next_sh;
  logic [7:0]  left;
  logic [7:0]  next_left;
  logic        rx;
  logic        next_rx;
  logic        rd;
  logic        next_rd;
  logic        first;
  logic        next_first;
  logic        scl_hi;
  logic        next_scl_hi;
  logic        sda_low;
  logic        next_sda_low;
  logic        nack;
  logic        next_nack;
  logic        rd_valid;
  logic        next_rd_valid;
  logic        done;
  logic        next_done;
  logic        tick;

  assign tick = (qcnt == Q_LAST) && state != tws_pkg::MST_IDLE && state != tws_pkg::MST_LOAD;

  // Next-state logic; outside start and stop, data changes only in quarter 0 while the clock is low.
  always_comb begin
    next_state    = state;
    next_qcnt     = tick ? 16'h0000 : qcnt + 16'h0001;
    next_phase    = tick ? phase + 2'h1 : phase;
    next_cnt      = cnt;
    next_sh       = sh;
    next_left     = left;
    next_rx       = rx;
    next_rd       = rd;
    next_first    = first;
    next_scl_hi   = scl_hi;
    next_sda_low  = sda_low;
    next_nack     = nack;
    next_rd_valid = 1'b0;
    next_done     = 1'b0;
    case (state)
      tws_pkg::MST_IDLE: begin
        next_qcnt = 16'h0000;
        if (cmd_valid_in) begin
          next_state = tws_pkg::MST_START;
          next_phase = 2'h0;
          next_sh    = {cmd_addr_in, cmd_read_in};
          next_rd    = cmd_read_in;
          next_left  = (cmd_read_in && cmd_len_in == 8'h00) ? 8'h01 : cmd_len_in;
          next_rx    = 1'b0;
          next_first = 1'b1;
          next_nack  = 1'b0;
        end
      end
      tws_pkg::MST_START: begin
        if (tick) begin
          case (phase)
            2'h0: next_sda_low = 1'b1;
            2'h1: next_scl_hi = 1'b0;
            2'h2: next_cnt = 3'h0;
            default: next_state = tws_pkg::MST_BITS;
          endcase
        end
      end
      tws_pkg::MST_LOAD: begin
        next_qcnt  = 16'h0000;
        next_phase = 2'h0;
        if (wr_valid_in) begin
          next_sh    = wr_data_in;
          next_left  = left - 8'h01;
          next_cnt   = 3'h0;
          next_state = tws_pkg::MST_BITS;
        end
      end
      tws_pkg::MST_BITS: begin
        if (tick) begin
          case (phase)
            2'h0: next_sda_low = rx ? 1'b0 : ~sh[7];
            2'h1: next_scl_hi = 1'b1;
            2'h2: next_sh = {sh[6:0], sda_sync[1]};
            default: begin
              next_scl_hi = 1'b0;
              next_cnt    = cnt + 3'h1;
              if (cnt == 3'h7) begin
                next_state = tws_pkg::MST_ACK;
              end
            end
          endcase
        end
      end
      tws_pkg::MST_ACK: begin
        if (tick) begin
          case (phase)
            2'h0: next_sda_low = rx && left != 8'h01;
            2'h1: next_scl_hi = 1'b1;
            2'h2: begin
              if (rx) begin
                next_rd_valid = 1'b1;
              end else begin
                next_nack = sda_sync[1];
              end
            end
            default: begin
              next_scl_hi = 1'b0;
              if (rx) begin
                next_left  = left - 8'h01;
                next_state = (left == 8'h01) ? tws_pkg::MST_STOP : tws_pkg::MST_BITS;
              end else if (nack) begin
                next_state = tws_pkg::MST_STOP;
              end else if (first && rd) begin
                next_rx    = 1'b1;
                next_state = tws_pkg::MST_BITS;
              end else begin
                next_state = (left == 8'h00) ? tws_pkg::MST_STOP : tws_pkg::MST_LOAD;
              end
              next_first = 1'b0;
              next_cnt   = 3'h0;
            end
          endcase
        end
      end
      tws_pkg::MST_STOP: begin
        if (tick) begin
          case (phase)
            2'h0: next_sda_low = 1'b1;
            2'h1: next_scl_hi = 1'b1;
            2'h2: next_sda_low = 1'b0;
            default: begin
              next_done  = 1'b1;
              next_state = tws_pkg::MST_IDLE;
            end
          endcase
        end
      end
      default: next_state = tws_pkg::MST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state    <= tws_pkg::MST_IDLE;
      qcnt     <= 16'h0000;
      phase    <= 2'h0;
      cnt      <= 3'h0;
      sh       <= 8'h00;
      left     <= 8'h00;
      rx       <= 1'b0;
      rd       <= 1'b0;
      first    <= 1'b0;
      scl_hi   <= 1'b1;
      sda_low  <= 1'b0;
      nack     <= 1'b0;
      rd_valid <= 1'b0;
      done     <= 1'b0;
    end else begin
      state    <= next_state;
      qcnt     <= next_qcnt;
      phase    <= next_phase;
      cnt      <= next_cnt;
      sh       <= next_sh;
      left     <= next_left;
      rx       <= next_rx;
      rd       <= next_rd;
      first    <= next_first;
      scl_hi   <= next_scl_hi;
      sda_low  <= next_sda_low;
      nack     <= next_nack;
      rd_valid <= next_rd_valid;
      done     <= next_done;
    end
  end

  assign link.scl       = scl_hi;
  assign link.sda_m_out = 1'b0;
  assign link.sda_m_oe  = sda_low;
  assign cmd_ready_out  = (state == tws_pkg::MST_IDLE);
  assign wr_ready_out   = (state == tws_pkg::MST_LOAD);
  assign rd_valid_out   = rd_valid;
  assign rd_data_out    = sh;
  assign done_out       = done;
  assign nack_out       = nack;
endmodule

// file: verification/tws_link_props.sv
/*
  Concurrent checks on the link between the master end and the memory end.
  Assumes it sits beside the link interface and sees both clocks and both resets.
*/
`timescale 1ns/10ps
module tws_link_props #(
  parameter int WR_CYCLES = tws_pkg::WR_CYCLES
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic link_clk_in,
  input wire logic link_reset_in,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_oe,
  input wire logic sda_d_out,
  input wire logic sda_d_oe,
  input wire logic busy_out,
  input wire logic standby_out
);
  // ==========================================================================
  // Frame tracking in the memory clock domain.
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic [4:0] cnt;
    logic       rw;
    logic       wr;
    logic       bst;
  } tws_trk_type;
  tws_trk_type trk;
  tws_trk_type next_trk;
  int          busy_cnt;
  int          next_busy_cnt;
  logic        rise_det;
  logic        start_det;
  logic        stop_det;

  // Edges are judged against the previous sample of the raw wires.
  assign rise_det  = scl & ~trk.scl;
  assign start_det = scl & trk.scl & trk.sda & ~sda;
  assign stop_det  = scl & trk.scl & ~trk.sda & sda;

  // The count parks at 31 outside frames, so no bit check fires before a start.
  always_comb begin
    next_trk      = trk;
    next_trk.scl  = scl;
    next_trk.sda  = sda;
    next_busy_cnt = busy_out ? busy_cnt + 1 : 0;
    if (start_det) begin
      next_trk.cnt = 5'h00;
      next_trk.wr  = 1'b0;
      next_trk.bst = busy_out;
    end else if (stop_det) begin
      next_trk.cnt = 5'h1F;
      next_trk.wr  = 1'b0;
    end else if (rise_det && trk.cnt != 5'h1F) begin
      next_trk.cnt = trk.cnt + 5'h01;
      if (trk.cnt == 5'h07) begin
        next_trk.rw = sda;
      end
      if (trk.cnt == 5'h11 && !trk.rw && !trk.bst) begin
        next_trk.wr = 1'b1;
      end
    end
  end

  // Registers only; the reset value makes the idle bus look like no frame.
  always_ff @(posedge link_clk_in) begin
    if (link_reset_in) begin
      trk      <= '{scl: 1'b1, sda: 1'b1, cnt: 5'h1F, default: 1'b0};
      busy_cnt <= 0;
    end else begin
      trk      <= next_trk;
      busy_cnt <= next_busy_cnt;
    end
  end

  // ==========================================================================
  // Properties.
  sequence s_busy_soon;
    ##[1:8] busy_out;
  endsequence
  sequence s_idle_soon;
    ##[1:8] standby_out;
  endsequence
  property p_drive_low;
    @(posedge link_clk_in) disable iff (link_reset_in) sda_d_oe |-> sda_d_out == 1'b0;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("memory drove the line high");
  property p_busy_quiet;
    @(posedge link_clk_in) disable iff (link_reset_in) busy_out |-> !sda_d_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("memory drove while busy");
  property p_scl_stable;
    @(posedge link_clk_in) disable iff (link_reset_in) scl && trk.scl |-> $stable(sda_d_oe);
  endproperty
  a_scl_stable: assert property (p_scl_stable) else $error("memory moved data with clock high");
  property p_addr_ack;
    @(posedge link_clk_in) disable iff (link_reset_in)
      rise_det && (trk.cnt == 5'h08 || (trk.cnt == 5'h11 && !trk.rw)) |-> sda == trk.bst;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("wrong acknowledge level");
  property p_wr_time;
    @(posedge link_clk_in) disable iff (link_reset_in) busy_out |-> busy_cnt < WR_CYCLES;
  endproperty
  a_wr_time: assert property (p_wr_time) else $error("write cycle too long");
  property p_commit;
    @(posedge link_clk_in) disable iff (link_reset_in) stop_det && trk.wr |-> s_busy_soon;
  endproperty
  a_commit: assert property (p_commit) else $error("no write cycle after stop");
  property p_stop_idle;
    @(posedge link_clk_in) disable iff (link_reset_in) stop_det && !trk.wr && !busy_out |-> s_idle_soon;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("no standby after stop");
  property p_stop_released;
    @(posedge clk_in) disable iff (reset_in) $fell(sda_m_oe) && scl |-> !sda_d_oe;
  endproperty
  a_stop_released: assert property (p_stop_released) else $error("stop while memory drove");
endmodule

// file: verification/two_wire_eeprom_slave_tb_top.sv
/*
  Self-checking bench joining the master end and the memory end on one link.
  Assumes shortened quarter and write-cycle counts so that the run stays short.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module two_wire_eeprom_slave_tb_top;
  localparam int QTR = 16;
  localparam int WRC = 400;
  typedef struct {
    logic       rd;
    logic [6:0] addr;
    logic [7:0] len;
    logic [7:0] base;
  } tws_row_type;
  // ==========================================================================
  // Ordinary transfers; writes come first so every read meets known contents.
  tws_row_type rows [6] = '{'{1'b0, 7'h40, 8'h01, 8'h5A}, '{1'b0, 7'h05, 8'h01, 8'hC3},
    '{1'b0, 7'h08, 8'h04, 8'h10}, '{1'b1, 7'h05, 8'h01, 8'h00},
    '{1'b1, 7'h08, 8'h04, 8'h00}, '{1'b1, 7'h40, 8'h01, 8'h00}};
  logic       clk        = 1'b0;
  logic       link_clk   = 1'b0;
  logic       reset      = 1'b1;
  logic       link_reset = 1'b1;
  logic       cmd_valid  = 1'b0;
  logic       cmd_read   = 1'b0;
  logic [6:0] cmd_addr   = 7'h00;
  logic [7:0] cmd_len    = 8'h00;
  logic       wr_valid   = 1'b0;
  logic [7:0] wr_data    = 8'h00;
  logic       cmd_ready;
  logic       wr_ready;
  logic       rd_valid;
  logic [7:0] rd_data;
  logic       done;
  logic       nack;
  logic       busy;
  logic       standby;
  logic       nack_g;
  logic [7:0] exp_mem [128];
  logic [7:0] wbuf [8];
  logic [7:0] rbuf [8];
  int         fails      = 0;
  int         n_compared = 0;

  always #5 clk = ~clk;
  // The link clock is offset by 3 ns; its edges drift against the master's and now and then meet them.
  initial begin
    #3;
    forever #16 link_clk = ~link_clk;
  end

  tws_link_if link ();
  tws_bus_master #(.QUARTER(QTR)) i_tws_bus_master (.clk_in(clk), .reset_in(reset), .link(link.master),
    .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_read_in(cmd_read), .cmd_addr_in(cmd_addr),
    .cmd_len_in(cmd_len), .wr_valid_in(wr_valid), .wr_data_in(wr_data), .wr_ready_out(wr_ready),
    .rd_valid_out(rd_valid), .rd_data_out(rd_data), .done_out(done), .nack_out(nack));
  tws_eeprom_dev #(.WR_CYCLES(WRC)) i_tws_eeprom_dev (.link_clk_in(link_clk), .reset_in(link_reset),
    .link(link.device), .busy_out(busy), .standby_out(standby));
  tws_link_props #(.WR_CYCLES(WRC)) i_tws_link_props (.clk_in(clk), .reset_in(reset),
    .link_clk_in(link_clk), .link_reset_in(link_reset), .scl(link.scl), .sda(link.sda),
    .sda_m_oe(link.sda_m_oe), .sda_d_out(link.sda_d_out), .sda_d_oe(link.sda_d_oe),
    .busy_out(busy), .standby_out(standby));

  // ==========================================================================
  // Transfer tasks.
  // Write bytes stay offered all along; the master takes one whenever it asks.
  task automatic run(input logic rd, input logic [6:0] a, input logic [7:0] n);
    int k;
    int wi;
    int ri;
    logic seen;
    wi        = 0;
    ri        = 0;
    seen      = 1'b0;
    // Stale bytes from an earlier read must not pass for missing ones.
    foreach (rbuf[j]) rbuf[j] = 'x;
    cmd_read  = rd;
    cmd_addr  = a;
    cmd_len   = n;
    wr_data   = wbuf[0];
    wr_valid  = ~rd;
    cmd_valid = 1'b1;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    #1 cmd_valid = 1'b0;
    for (k = 0; k < 20000 && !seen; k++) begin
      @(posedge clk);
      if (rd_valid === 1'b1) begin
        rbuf[ri[2:0]] = rd_data;
        ri++;
      end
      if (wr_ready === 1'b1) begin
        wi++;
      end
      seen   = (done === 1'b1);
      nack_g = nack;
      #1;
      if (!seen) wr_data = wbuf[wi[2:0]];
    end
    // A transfer that never finishes is a failure of its own.
    if (!seen) begin
      fails++;
      summarize();
    end
  endtask

  // A write, a refused write while busy, then polling until the memory answers.
  task automatic wr(input logic [6:0] a, input logic [7:0] n, input logic [7:0] b);
    int i;
    for (i = 0; i < 8; i++) wbuf[i] = b + 8'(i);
    run(1'b0, a, n);
    `CHK(nack_g, 1'b0)
    `CHK(busy, 1'b1)
    for (i = 0; i < n; i++) exp_mem[{a[6:2], a[1:0] + 2'(i)}] = wbuf[i];
    run(1'b0, 7'h40, 8'h01);
    `CHK(nack_g, 1'b1)
    for (i = 0; i < 8 && nack_g === 1'b1; i++) run(1'b0, a, 8'h00);
    `CHK(nack_g, 1'b0)
    `CHK(busy, 1'b0)
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] n);
    int i;
    run(1'b1, a, n);
    `CHK(nack_g, 1'b0)
    for (i = 0; i < n; i++) `CHK(rbuf[i], exp_mem[7'(a + 7'(i))])
    `CHK(standby, 1'b1)
  endtask

  task automatic idle_check();
    `CHK(link.scl, 1'b1)
    `CHK(link.sda, 1'b1)
    `CHK(cmd_ready, 1'b1)
    `CHK(standby, 1'b1)
    `CHK(busy, 1'b0)
  endtask

  task automatic summarize();
    if (fails == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // The tests need some 40,000 master cycles; 90,000 means a hang.
  initial begin
    #900000;
    fails++;
    summarize();
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (3) @(posedge clk);
    #1 reset = 1'b0;
    repeat (3) @(posedge link_clk);
    @(posedge clk);
    #1 link_reset = 1'b0;
    idle_check();
    foreach (rows[r]) begin
      if (rows[r].rd) begin
        rd(rows[r].addr, rows[r].len);
      end else begin
        wr(rows[r].addr, rows[r].len, rows[r].base);
      end
    end
    // Six bytes into one page wrap onto its first slots.
    wr(7'h1E, 8'h06, 8'hA0);
    rd(7'h1C, 8'h04);
    // A sequential read across the top of the array.
    wr(7'h7C, 8'h04, 8'hE0);
    wr(7'h00, 8'h02, 8'h70);
    rd(7'h7E, 8'h04);
    // Reset in mid-address: both ends must drop the frame and stand idle.
    cmd_addr  = 7'h33;
    cmd_valid = 1'b1;
    repeat (300) @(posedge clk);
    #1 cmd_valid = 1'b0;
    reset      = 1'b1;
    link_reset = 1'b1;
    repeat (8) @(posedge clk);
    idle_check();
    #1 reset = 1'b0;
    link_reset = 1'b0;
    rd(7'h05, 8'h01);
    summarize();
  end
endmodule
